// File: design/lrsa_top.v
// timekeeping, sampling interval and temperature alarm core of the logger
`default_nettype none
`include "lrsa_map.vh"

module lrsa_top #(
    parameter CYCLES_PER_SEC = `LRSA_SECOND_NS / `LRSA_CLK_NS
) (
    input wire mclk,
    input wire sys_rst,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire mission_active,
    input wire logging_format_select,
    input wire conv_valid,
    input wire [10:0] conv_code,
    input wire conv_under,
    input wire conv_over,
    input wire alarm_clear,
    output wire oscillator_enable,
    output wire seconds_unit_select,
    output reg sample_tick,
    output wire low_alarm_flag,
    output wire high_alarm_flag,
    output wire [7:0] result_high_byte,
    output wire [7:0] result_low_byte
);

    // bcd increment of one byte, wrap value chosen by caller
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9)
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            else
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // two-digit bcd year divisible by four, 00 included
    function leap_year;
        input [7:0] y;
        begin
            if (y[4] == 1'b0)
                leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                    (y[3:0] == 4'h8);
            else
                leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    endfunction

    // last bcd day of a bcd month
    function [7:0] month_len;
        input [7:0] m;
        input [7:0] y;
        begin
            case (m)
                8'h02: month_len = leap_year(y) ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
                default: month_len = 8'h31;
            endcase
        end
    endfunction

    reg [7:0] sec_q;
    reg [7:0] min_q;
    reg [7:0] hour_q;
    reg [7:0] day_q;
    reg [7:0] mon_q;
    reg [7:0] year_q;
    reg [13:0] ivl_q;
    reg [7:0] thr_lo_q;
    reg [7:0] thr_hi_q;
    reg [1:0] alm_en_q;
    reg [1:0] ctl_q;
    reg [15:0] res_q;
    reg lo_flag_q;
    reg hi_flag_q;
    reg [27:0] div_q;
    reg [5:0] pre_q;
    reg [13:0] ivl_cnt_q;
    // bcd successors of the hour and month digits, cut to field width
    reg [7:0] h12_inc;
    reg [7:0] h24_inc;
    reg [7:0] mon_inc;

    // last divider count of each second; the divider is 28 bits wide,
    // so one second may not span more than 2^28 clock cycles
    localparam [27:0] DIV_LAST = CYCLES_PER_SEC[27:0] - 28'h0000001;

    wire sec_tick;
    wire wr_free;
    wire [7:0] hi_byte;
    reg [7:0] sec_d;
    reg [7:0] min_d;
    reg [7:0] hour_d;
    reg [7:0] day_d;
    reg [7:0] mon_d;
    reg [7:0] year_d;
    reg [7:0] rd_d;

    // configuration writes only between missions
    assign wr_free = reg_wr && !mission_active;
    assign oscillator_enable = ctl_q[`LRSA_CTL_OSC_BIT];
    assign seconds_unit_select = ctl_q[`LRSA_CTL_SECU_BIT];
    assign low_alarm_flag = lo_flag_q;
    assign high_alarm_flag = hi_flag_q;
    assign result_high_byte = res_q[15:8];
    assign result_low_byte = res_q[7:0];

    // one-second timebase; a stopped oscillator freezes the clock
    always @(posedge mclk)
    begin
        if (sys_rst)
            div_q <= 28'h0000000;
        else if (!oscillator_enable)
            div_q <= 28'h0000000;
        else if (div_q == DIV_LAST)
            div_q <= 28'h0000000;
        else
            div_q <= div_q + 28'h0000001;
    end

    assign sec_tick = oscillator_enable &&
        (div_q == DIV_LAST);

    // ripple of the bcd clock fields on a second tick
    always @*
    begin
        sec_d = sec_q;
        min_d = min_q;
        hour_d = hour_q;
        day_d = day_q;
        mon_d = mon_q;
        year_d = year_q;
        // successors of the raw digits; only the field bits are kept
        h12_inc = bcd_inc({3'h0, hour_q[4:0]});
        h24_inc = bcd_inc({2'h0, hour_q[5:0]});
        mon_inc = bcd_inc({3'h0, mon_q[4:0]});
        if (sec_tick)
        begin
            if (sec_q[6:0] != 7'h59)
                sec_d = bcd_inc(sec_q);
            else
            begin
                sec_d = 8'h00;
                if (min_q[6:0] != 7'h59)
                    min_d = bcd_inc(min_q);
                else
                begin
                    min_d = 8'h00;
                    if (hour_q[`LRSA_HOUR_12_BIT])
                    begin
                        // 12-hour: 11 to 12 flips pm, 12 wraps to 01
                        if (hour_q[4:0] == 5'h12)
                            hour_d = {hour_q[7:5], 5'h01};
                        else
                        begin
                            hour_d = {hour_q[7:5], h12_inc[4:0]};
                            if (hour_q[4:0] == 5'h11)
                                hour_d[`LRSA_HOUR_PM_BIT] =
                                    ~hour_q[`LRSA_HOUR_PM_BIT];
                        end
                    end
                    else if (hour_q[5:0] == 6'h23)
                        hour_d = {hour_q[7:6], 6'h00};
                    else
                        hour_d = {hour_q[7:6], h24_inc[5:0]};
                    if (hour_d[5:0] == 6'h00 ||
                        (hour_q[`LRSA_HOUR_12_BIT] &&
                        hour_q[`LRSA_HOUR_PM_BIT] && hour_q[4:0] == 5'h11))
                    begin
                        // a new day starts at midnight in either mode
                        if (day_q[5:0] != month_len(mon_q[4:0] & 8'h1f,
                            year_q))
                            day_d = bcd_inc(day_q);
                        else
                        begin
                            day_d = 8'h01;
                            if (mon_q[4:0] != 5'h12)
                                // century bit must ride along a month step
                                mon_d = {mon_q[7], 2'h0, mon_inc[4:0]};
                            else
                            begin
                                mon_d = {mon_q[7], 7'h01};
                                if (year_q == 8'h99)
                                begin
                                    year_d = 8'h00;
                                    mon_d[`LRSA_MON_CENTURY_BIT] =
                                        ~mon_q[`LRSA_MON_CENTURY_BIT];
                                end
                                else
                                    year_d = bcd_inc(year_q);
                            end
                        end
                    end
                end
            end
        end
    end

    // clock fields: a software write wins over the tick
    // they stay writable in a mission; only configuration is locked
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sec_q <= `LRSA_RST_SEC;
            min_q <= `LRSA_RST_MIN;
            hour_q <= `LRSA_RST_HOUR;
            day_q <= `LRSA_RST_DAY;
            mon_q <= `LRSA_RST_MON;
            year_q <= `LRSA_RST_YEAR;
        end
        else
        begin
            sec_q <= (reg_wr && reg_addr == `LRSA_OFF_SEC) ?
                {1'b0, reg_wdata[6:0]} : sec_d;
            min_q <= (reg_wr && reg_addr == `LRSA_OFF_MIN) ?
                {1'b0, reg_wdata[6:0]} : min_d;
            hour_q <= (reg_wr && reg_addr == `LRSA_OFF_HOUR) ?
                {1'b0, reg_wdata[6:0]} : hour_d;
            day_q <= (reg_wr && reg_addr == `LRSA_OFF_DAY) ?
                {2'h0, reg_wdata[5:0]} : day_d;
            mon_q <= (reg_wr && reg_addr == `LRSA_OFF_MON) ?
                {reg_wdata[7], 2'h0, reg_wdata[4:0]} : mon_d;
            year_q <= (reg_wr && reg_addr == `LRSA_OFF_YEAR) ?
                reg_wdata : year_d;
        end
    end

    // configuration registers, frozen while a mission runs
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ivl_q <= `LRSA_RST_IVL;
            thr_lo_q <= `LRSA_RST_THR_LO;
            thr_hi_q <= `LRSA_RST_THR_HI;
            alm_en_q <= `LRSA_RST_ALM_EN;
            ctl_q <= `LRSA_RST_CTL;
        end
        else if (wr_free)
        begin
            case (reg_addr)
                `LRSA_OFF_IVL_LO: ivl_q[7:0] <= reg_wdata;
                `LRSA_OFF_IVL_HI: ivl_q[13:8] <= reg_wdata[5:0];
                `LRSA_OFF_LO_THR: thr_lo_q <= reg_wdata;
                `LRSA_OFF_HI_THR: thr_hi_q <= reg_wdata;
                `LRSA_OFF_ALM_EN: alm_en_q <= reg_wdata[1:0];
                `LRSA_OFF_CLK_CTL: ctl_q <= reg_wdata[1:0];
                default: ctl_q <= ctl_q;
            endcase
        end
    end

    // minute prescaler feeds the interval counter when unit is minutes
    always @(posedge mclk)
    begin
        if (sys_rst || !mission_active)
            pre_q <= 6'h00;
        else if (sec_tick)
            pre_q <= (pre_q == `LRSA_SEC_PER_MIN - 6'd1) ?
                6'h00 : pre_q + 6'h01;
    end

    // interval counter; a zero interval wraps and fires every 16384 units
    always @(posedge mclk)
    begin
        sample_tick <= 1'b0;
        if (sys_rst || !mission_active)
            ivl_cnt_q <= 14'h0000;
        else if (sec_tick && (seconds_unit_select ||
            pre_q == `LRSA_SEC_PER_MIN - 6'd1))
        begin
            if (ivl_cnt_q + 14'h0001 == ivl_q)
            begin
                ivl_cnt_q <= 14'h0000;
                sample_tick <= 1'b1;
            end
            else
                ivl_cnt_q <= ivl_cnt_q + 14'h0001;
        end
        if (sys_rst)
            sample_tick <= 1'b0;
    end

    // result encoding: code carries twice celsius plus variant offset
    always @(posedge mclk)
    begin
        if (sys_rst)
            res_q <= `LRSA_RES_UNDER;
        else if (conv_valid)
        begin
            if (conv_under)
                res_q <= `LRSA_RES_UNDER;
            else if (conv_over)
                res_q <= logging_format_select ? `LRSA_RES_OVER16 :
                    {`LRSA_RES_OVER8, 8'h00};
            else if (logging_format_select)
                res_q <= {conv_code, 5'h00};
            else
                res_q <= {conv_code[10:3], 8'h00};
        end
    end

    // alarms look at the high byte only
    assign hi_byte = conv_under ? 8'h00 : conv_over ? 8'hff :
        conv_code[10:3];

    // sticky alarm flags; a new alarm wins over a clear
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            lo_flag_q <= 1'b0;
            hi_flag_q <= 1'b0;
        end
        else
        begin
            // set checked first so a same-cycle clear cannot lose an alarm
            if (conv_valid && mission_active &&
                alm_en_q[`LRSA_ALM_LO_EN_BIT] && hi_byte <= thr_lo_q)
                lo_flag_q <= 1'b1;
            else if (alarm_clear)
                lo_flag_q <= 1'b0;
            if (conv_valid && mission_active &&
                alm_en_q[`LRSA_ALM_HI_EN_BIT] && hi_byte >= thr_hi_q)
                hi_flag_q <= 1'b1;
            else if (alarm_clear)
                hi_flag_q <= 1'b0;
        end
    end

    // read mux; unmapped addresses read zero
    // in 8-bit mode the low result byte is undefined; it reads zero here
    always @*
    begin
        case (reg_addr)
            `LRSA_OFF_SEC: rd_d = sec_q;
            `LRSA_OFF_MIN: rd_d = min_q;
            `LRSA_OFF_HOUR: rd_d = hour_q;
            `LRSA_OFF_DAY: rd_d = day_q;
            `LRSA_OFF_MON: rd_d = mon_q;
            `LRSA_OFF_YEAR: rd_d = year_q;
            `LRSA_OFF_IVL_LO: rd_d = ivl_q[7:0];
            `LRSA_OFF_IVL_HI: rd_d = {2'h0, ivl_q[13:8]};
            `LRSA_OFF_LO_THR: rd_d = thr_lo_q;
            `LRSA_OFF_HI_THR: rd_d = thr_hi_q;
            `LRSA_OFF_RES_LO: rd_d = res_q[7:0];
            `LRSA_OFF_RES_HI: rd_d = res_q[15:8];
            `LRSA_OFF_ALM_EN: rd_d = {6'h00, alm_en_q};
            `LRSA_OFF_CLK_CTL: rd_d = {6'h00, ctl_q};
            default: rd_d = 8'h00;
        endcase
    end

    // read data appears the cycle after the strobe only
    always @(posedge mclk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_d;
        else
            reg_rdata <= 8'h00;
    end

endmodule // lrsa_top
`default_nettype wire

// File: pkg/lrsa_map.vh
// register map, field positions, reset values and timing of the logger core
// How it works
// - hours bit 6 selects 12-hour counting
// - hours bit 5 is PM or twenties digit
// - century flag inverts when years wrap 99
// - leap day when year 00 or multiple of 4
// - interval is 14-bit binary, 1 to 16383
// - interval unit seconds when select bit set
// - interval read-only in mission, spare bits zero
// - results in half or sixteenth degree steps
// - high byte valid, low byte top three bits
// - underrange all zeros, overrange all ones
// - code is twice celsius plus offset
// - one-byte low and high thresholds
// - alarms compare only the result high byte
// - low flag when enabled and result at/below
// - high flag when enabled and result at/above
// - alarm enables in bits 0 and 1 only
// - clock control: oscillator and unit bits
// - oscillator runs only while its enable set
// - clock and calendar registers held in BCD
// - format select picks 8 or 16-bit results
`ifndef LRSA_MAP_VH
`define LRSA_MAP_VH

`define LRSA_ADDR_W 10
`define LRSA_OFF_SEC 10'h200
`define LRSA_OFF_MIN 10'h201
`define LRSA_OFF_HOUR 10'h202
`define LRSA_OFF_DAY 10'h203
`define LRSA_OFF_MON 10'h204
`define LRSA_OFF_YEAR 10'h205
`define LRSA_OFF_IVL_LO 10'h206
`define LRSA_OFF_IVL_HI 10'h207
`define LRSA_OFF_LO_THR 10'h208
`define LRSA_OFF_HI_THR 10'h209
`define LRSA_OFF_RES_LO 10'h20c
`define LRSA_OFF_RES_HI 10'h20d
`define LRSA_OFF_ALM_EN 10'h210
`define LRSA_OFF_CLK_CTL 10'h212

`define LRSA_HOUR_12_BIT 6
`define LRSA_HOUR_PM_BIT 5
`define LRSA_MON_CENTURY_BIT 7
`define LRSA_ALM_LO_EN_BIT 0
`define LRSA_ALM_HI_EN_BIT 1
`define LRSA_CTL_OSC_BIT 0
`define LRSA_CTL_SECU_BIT 1

`define LRSA_RST_SEC 8'h00
`define LRSA_RST_MIN 8'h00
`define LRSA_RST_HOUR 8'h00
`define LRSA_RST_DAY 8'h01
`define LRSA_RST_MON 8'h01
`define LRSA_RST_YEAR 8'h00
`define LRSA_RST_IVL 14'h0001
`define LRSA_RST_THR_LO 8'h00
`define LRSA_RST_THR_HI 8'hff
`define LRSA_RST_ALM_EN 2'h0
`define LRSA_RST_CTL 2'h0

`define LRSA_RES_UNDER 16'h0000
`define LRSA_RES_OVER16 16'hffe0
`define LRSA_RES_OVER8 8'hff

`define LRSA_SECOND_NS 1000000000
`define LRSA_CLK_NS 5
`define LRSA_SEC_PER_MIN 6'd60

`endif

// File: verif/logger_rtc_sample_alarm_test.sv
// self-checking bench for the logger clock, interval and alarm core
`default_nettype none
module logger_rtc_sample_alarm_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [7:0] wd = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic mis = 1'b0;
    logic lfs = 1'b1;
    logic cvv = 1'b0;
    logic [10:0] code = 11'h000;
    logic und = 1'b0;
    logic ovr = 1'b0;
    logic clr_s = 1'b0;
    wire [7:0] rdat;
    wire [7:0] rhi;
    wire [7:0] rlo;
    wire osc;
    wire secu;
    wire tick;
    wire lo_f;
    wire hi_f;
    int errors = 0;
    int comparisons = 0;
    logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
        8'h01, 8'h00, 8'h00, 8'hff};
    logic [9:0] a;

    // four cycles a second keeps minute rollovers short
    lrsa_top #(.CYCLES_PER_SEC(4)) dut (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .reg_addr(addr),
        .reg_wdata(wd),
        .reg_wr(wr_s),
        .reg_rd(rd_s),
        .reg_rdata(rdat),
        .mission_active(mis),
        .logging_format_select(lfs),
        .conv_valid(cvv),
        .conv_code(code),
        .conv_under(und),
        .conv_over(ovr),
        .alarm_clear(clr_s),
        .oscillator_enable(osc),
        .seconds_unit_select(secu),
        .sample_tick(tick),
        .low_alarm_flag(lo_f),
        .high_alarm_flag(hi_f),
        .result_high_byte(rhi),
        .result_low_byte(rlo)
    );

    // 200 MHz clock
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] ad, input logic [7:0] d);
        @(posedge mclk);
        wr_s <= 1'b1;
        addr <= ad;
        wd <= d;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] ad, input logic [7:0] e);
        @(posedge mclk);
        rd_s <= 1'b1;
        addr <= ad;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 chk(rdat, e);
    endtask

    task automatic cv(input logic [10:0] c, input logic u, input logic o);
        @(posedge mclk);
        cvv <= 1'b1;
        code <= c;
        und <= u;
        ovr <= o;
        @(posedge mclk);
        cvv <= 1'b0;
        #1;
    endtask

    task automatic clr();
        @(posedge mclk);
        clr_s <= 1'b1;
        @(posedge mclk);
        clr_s <= 1'b0;
    endtask

    task automatic set_mis(input logic m);
        @(posedge mclk);
        mis <= m;
    endtask

    // seconds field is not checked: up to three ticks may land
    task automatic roll(input logic [7:0] h, d, m, y, eh, ed, em, ey);
        wr(10'h200, 8'h59);
        wr(10'h201, 8'h59);
        wr(10'h202, h);
        wr(10'h203, d);
        wr(10'h204, m);
        wr(10'h205, y);
        wr(10'h212, 8'h01);
        repeat (10) @(posedge mclk);
        wr(10'h212, 8'h00);
        rd(10'h201, 8'h00);
        rd(10'h202, eh);
        rd(10'h203, ed);
        rd(10'h204, em);
        rd(10'h205, ey);
    endtask

    // cycles between two ticks, bounded so a dead tick cannot hang
    task automatic gap(input logic [19:0] e);
        int n;
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(posedge mclk);
                #1 n++;
            end while (tick !== 1'b1 && n < 2000);
        end
        chk(20'(n), e);
    endtask

    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // run stays near 1k cycles; the limit leaves ample margin
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge mclk);
        for (a = 10'h200; a < 10'h20a; a++)
            rd(a, rv[a - 10'h200]);
        wr(10'h211, 8'hff);
        rd(10'h211, 8'h00);
        wr(10'h210, 8'hff);
        rd(10'h210, 8'h03);
        wr(10'h212, 8'hfe);
        rd(10'h212, 8'h02);
        chk({osc, secu}, 2'b01);
        wr(10'h207, 8'hff);
        wr(10'h206, 8'hff);
        rd(10'h207, 8'h3f);
        rd(10'h206, 8'hff);
        wr(10'h208, 8'h3e);
        wr(10'h209, 8'h85);
        rd(10'h208, 8'h3e);
        rd(10'h209, 8'h85);
        cv(11'h000, 1'b1, 1'b0);
        chk({lo_f, hi_f, rhi, rlo}, 18'h0);
        set_mis(1'b1);
        wr(10'h212, 8'h01);
        rd(10'h212, 8'h02);
        wr(10'h210, 8'h00);
        rd(10'h210, 8'h03);
        wr(10'h206, 8'h05);
        rd(10'h206, 8'hff);
        cv(11'h1f7, 1'b0, 1'b0);
        chk({lo_f, hi_f, rhi, rlo}, 18'h23ee0);
        cv(11'h428, 1'b0, 1'b0);
        chk({lo_f, hi_f}, 2'b11);
        clr();
        cv(11'h1f8, 1'b0, 1'b0);
        cv(11'h427, 1'b0, 1'b0);
        chk({lo_f, hi_f, rhi, rlo}, 18'h084e0);
        cv(11'h0bb, 1'b0, 1'b0);
        chk({rhi, rlo}, 16'h1760);
        cv(11'h000, 1'b0, 1'b1);
        chk({rhi, rlo}, 16'hffe0);
        @(posedge mclk) lfs <= 1'b0;
        cv(11'h000, 1'b0, 1'b1);
        chk(rhi, 8'hff);
        cv(11'h2a0, 1'b0, 1'b0);
        chk(rhi, 8'h54);
        set_mis(1'b0);
        wr(10'h210, 8'h00);
        set_mis(1'b1);
        clr();
        cv(11'h7f8, 1'b0, 1'b0);
        cv(11'h000, 1'b1, 1'b0);
        chk({lo_f, hi_f}, 2'b00);
        set_mis(1'b0);
        wr(10'h206, 8'h02);
        wr(10'h207, 8'h00);
        wr(10'h212, 8'h03);
        set_mis(1'b1);
        gap(8);
        set_mis(1'b0);
        wr(10'h206, 8'h01);
        wr(10'h212, 8'h01);
        set_mis(1'b1);
        gap(240);
        set_mis(1'b0);
        wr(10'h212, 8'h00);
        roll(8'h23, 8'h28, 8'h02, 8'h03, 8'h00, 8'h01, 8'h03, 8'h03);
        roll(8'h23, 8'h28, 8'h02, 8'h04, 8'h00, 8'h29, 8'h02, 8'h04);
        roll(8'h23, 8'h28, 8'h02, 8'h00, 8'h00, 8'h29, 8'h02, 8'h00);
        roll(8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h81, 8'h00);
        roll(8'h23, 8'h31, 8'h92, 8'h99, 8'h00, 8'h01, 8'h01, 8'h00);
        roll(8'h71, 8'h30, 8'h04, 8'h05, 8'h52, 8'h01, 8'h05, 8'h05);
        roll(8'h51, 8'h15, 8'h06, 8'h07, 8'h72, 8'h15, 8'h06, 8'h07);
        roll(8'h19, 8'h15, 8'h06, 8'h07, 8'h20, 8'h15, 8'h06, 8'h07);
        roll(8'h23, 8'h30, 8'h84, 8'h10, 8'h00, 8'h01, 8'h85, 8'h10);
        roll(8'h52, 8'h15, 8'h06, 8'h07, 8'h41, 8'h15, 8'h06, 8'h07);
        report_and_stop();
    end
endmodule // logger_rtc_sample_alarm_test
`default_nettype wire

// File: verif/lrsa_properties.sv
// port-level assertion checker for the logger core
`default_nettype none
module lrsa_properties #(
    parameter CYCLES_PER_SEC = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic mission_active,
    input wire logic logging_format_select,
    input wire logic conv_valid,
    input wire logic [10:0] conv_code,
    input wire logic conv_under,
    input wire logic conv_over,
    input wire logic oscillator_enable,
    input wire logic seconds_unit_select,
    input wire logic low_alarm_flag,
    input wire logic high_alarm_flag,
    input wire logic [7:0] result_high_byte,
    input wire logic [7:0] result_low_byte
);
    // one clock domain, synchronous reset masks every check
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // slices taken once so $past only ever sees plain signals
    wire [15:0] res = {result_high_byte, result_low_byte};
    wire [1:0] wd_lo = reg_wdata[1:0];
    wire [7:0] code_hi = conv_code[10:3];

    sequence s_ctl_wr;
        reg_wr && reg_addr == 10'h212;
    endsequence
    sequence s_conv_ok;
        conv_valid && !conv_under && !conv_over;
    endsequence

    AST_CTL_WR: assert property (
        s_ctl_wr ##0 !mission_active |=>
        {seconds_unit_select, oscillator_enable} == $past(wd_lo))
        else $error("control write lost");
    AST_CTL_LOCK: assert property (
        s_ctl_wr ##0 mission_active |=>
        $stable({seconds_unit_select, oscillator_enable}))
        else $error("control changed in mission");
    AST_CTL_RD: assert property (
        reg_rd && reg_addr == 10'h212 |=>
        reg_rdata == {6'h00, seconds_unit_select, oscillator_enable})
        else $error("control readback wrong");
    AST_ALM_SPARE: assert property (
        reg_rd && reg_addr == 10'h210 |=> reg_rdata[7:2] == 6'h00)
        else $error("alarm enable spare bits set");
    AST_IVL_SPARE: assert property (
        reg_rd && reg_addr == 10'h207 |=> reg_rdata[7:6] == 2'h0)
        else $error("interval spare bits set");
    AST_RES_WIDE: assert property (
        s_conv_ok ##0 logging_format_select |=>
        res == {$past(conv_code), 5'h00})
        else $error("wide result wrong");
    AST_RES_BYTE: assert property (
        s_conv_ok ##0 !logging_format_select |=>
        result_high_byte == $past(code_hi))
        else $error("byte result wrong");
    AST_UNDER: assert property (
        conv_valid && conv_under |=> res == 16'h0000)
        else $error("underrange code wrong");
    AST_OVER: assert property (
        conv_valid && conv_over && !conv_under |=>
        result_high_byte == 8'hff)
        else $error("overrange code wrong");
    AST_LO_GATE: assert property (
        $rose(low_alarm_flag) |->
        $past(conv_valid) && $past(mission_active))
        else $error("low flag set without mission result");
    AST_HI_GATE: assert property (
        $rose(high_alarm_flag) |->
        $past(conv_valid) && $past(mission_active))
        else $error("high flag set without mission result");
endmodule // lrsa_properties

bind lrsa_top lrsa_properties #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_props (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .mission_active(mission_active),
    .logging_format_select(logging_format_select),
    .conv_valid(conv_valid),
    .conv_code(conv_code),
    .conv_under(conv_under),
    .conv_over(conv_over),
    .oscillator_enable(oscillator_enable),
    .seconds_unit_select(seconds_unit_select),
    .low_alarm_flag(low_alarm_flag),
    .high_alarm_flag(high_alarm_flag),
    .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte)
);
`default_nettype wire
